/* hw/sfl_flash_cmd.sv */
`timescale 1ns/1ps
module sfl_flash_cmd #(
  parameter int TW_NS = sfl_pkg::TW_NS_DEFAULT
) (
  // Core clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Serial link.
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  output sfl_pkg::sfl_pins_t io_drive_out,
  // Protection and mode pins.
  input wire logic wp_n_in,
  input wire logic four_line_mode_in,
  // Array read port, on the serial clock.
  output logic [23:0] array_addr_out,
  input wire logic [7:0] array_data_in,
  // Status view.
  output logic [23:0] status_out,
  output logic write_in_progress_flag_out
);
  import sfl_pkg::*;

  // Cycle length in core clocks, rounded up and never below one.
  localparam longint TW_PS = longint'(TW_NS) * 64'd1000;
  localparam longint TW_RAW = (TW_PS + longint'(CLK_PERIOD_PS) - 64'd1) / longint'(CLK_PERIOD_PS);
  localparam int TW_CYCLES = (TW_RAW < 64'd1) ? 1 : int'(TW_RAW);

  typedef enum logic [2:0] {
    PH_OPC,
    PH_ADR,
    PH_DUM,
    PH_OUT,
    PH_IN,
    PH_IGN
  } sfl_phase_t;

  // Link side state.
  logic frame_rst;
  sfl_phase_t phase;
  logic [5:0] cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [2:0] lanes;
  logic [2:0] in_w;
  logic [2:0] out_cnt;
  logic [7:0] ob;
  logic [7:0] next_byte;
  logic [7:0] stat_byte;
  logic opc_last;
  logic adr_last;
  logic dum_last;
  logic out_last;
  sfl_cmd_t cmd;
  sfl_core_t core_info;
  sfl_core_t core_s1;
  sfl_core_t core_s2;
  logic qpi_s1;
  logic qpi_s2;
  logic qpi_l;
  logic busy_l;

  // Core side state.
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  logic wp_s1;
  logic wp_s2;
  logic seen_tag;
  logic fresh;
  logic hw_prot;
  logic is_wr;
  logic len_ok;
  logic wr_go;
  logic soft_rst;
  logic tw_done;
  logic vol_wen;
  logic rst_arm;
  logic [1:0] dummy_sel;
  logic [7:0] byte1;
  logic [23:0] wr_val;
  logic [23:0] wr_sel;
  logic [23:0] merged;
  logic [23:0] pending;
  logic [23:0] next_status;
  logic [31:0] tw_cnt;

  // A high chip select ends the frame and clears all frame state except the captured command.
  assign frame_rst = rst_in | cs_n_in;
  assign core_info = '{status: status_out, dummy_sel: dummy_sel};
  assign write_in_progress_flag_out = status_out[WIP_BIT];

  // The link clock stops between frames, so this view is stale until the second
  // clock of the next frame; the shortest opcode phase still covers that gap.
  // Core state and the mode pin are brought onto the serial clock.
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      core_s1 <= '0;
      core_s2 <= '0;
      qpi_s1 <= 1'b0;
      qpi_s2 <= 1'b0;
    end else begin
      core_s1 <= core_info;
      core_s2 <= core_s1;
      qpi_s1 <= four_line_mode_in;
      qpi_s2 <= qpi_s1;
    end
  end

  // Phase ends and the next shift value for the incoming lines.
  always_comb begin
    qpi_l = qpi_s2;
    busy_l = core_s2.status[WIP_BIT];
    in_w = qpi_l ? 3'h4 : 3'h1;
    next_sh = qpi_l ? {sh[3:0], io_in} : {sh[6:0], io_in[0]};
    opc_last = cnt == (qpi_l ? OPC_LAST_QPI : OPC_LAST_SPI);
    adr_last = cnt == (qpi_l ? ADDR_LAST_QPI : ADDR_LAST_SPI);
    dum_last = cnt == (qpi_l ? dummy_last(core_s2.dummy_sel) : DUMMY_LAST_SPI);
    out_last = out_cnt == byte_last(lanes);
  end

  // Frame sequencer: opcode, address, dummy and data phases on rising edges.
  always_ff @(posedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      phase <= PH_OPC;
      cnt <= 6'h00;
      sh <= 8'h00;
      lanes <= 3'h1;
      out_cnt <= 3'h0;
    end else begin
      sh <= next_sh;
      unique case (phase)
        PH_OPC: begin
          cnt <= opc_last ? 6'h00 : 6'(cnt + 6'h01);
          if (opc_last) begin
            lanes <= in_w;
            case (next_sh)
              OP_RD_STAT1, OP_RD_STAT2, OP_RD_STAT3: begin
                phase <= PH_OUT;
              end
              OP_READ: begin
                phase <= (!qpi_l && !busy_l) ? PH_ADR : PH_IGN;
              end
              OP_FAST_READ: begin
                phase <= PH_ADR;
              end
              OP_DUAL_READ: begin
                phase <= qpi_l ? PH_IGN : PH_ADR;
                lanes <= 3'h2;
              end
              OP_QUAD_READ: begin
                phase <= qpi_l ? PH_IGN : PH_ADR;
                lanes <= 3'h4;
              end
              OP_WR_STAT1, OP_WR_STAT2, OP_WR_STAT3, OP_SET_PARAM: begin
                phase <= PH_IN;
              end
              default: begin
                phase <= PH_IGN;
              end
            endcase
          end
        end
        PH_ADR: begin
          cnt <= adr_last ? 6'h00 : 6'(cnt + 6'h01);
          if (adr_last) begin
            phase <= (cmd.op == OP_READ) ? PH_OUT : PH_DUM;
          end
        end
        PH_DUM: begin
          cnt <= dum_last ? 6'h00 : 6'(cnt + 6'h01);
          if (dum_last) begin
            phase <= PH_OUT;
          end
        end
        PH_OUT: begin
          out_cnt <= out_last ? 3'h0 : 3'(out_cnt + 3'h1);
        end
        PH_IN: begin
          phase <= PH_IN;
        end
        PH_IGN: begin
          phase <= PH_IGN;
        end
        default: begin
          phase <= PH_IGN;
        end
      endcase
    end
  end

  // Address capture and increment after each array byte.
  always_ff @(posedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      array_addr_out <= 24'h000000;
    end else if (phase == PH_ADR) begin
      if (qpi_l) begin
        array_addr_out <= {array_addr_out[19:0], io_in};
      end else begin
        array_addr_out <= {array_addr_out[22:0], io_in[0]};
      end
    end else if (phase == PH_OUT && out_last && !is_status_read(cmd.op)) begin
      array_addr_out <= 24'(array_addr_out + 24'h000001);
    end
  end

  // Command capture; kept across chip select so the core can read it afterwards.
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd <= '0;
    end else if (phase == PH_OPC && opc_last) begin
      cmd.op <= next_sh;
      cmd.tag <= ~cmd.tag;
      cmd.din <= 16'h0000;
      cmd.nbits <= 5'h00;
    end else if (phase == PH_IN) begin
      cmd.din <= qpi_l ? {cmd.din[11:0], io_in} : {cmd.din[14:0], io_in[0]};
      if (cmd.nbits < DIN_BITS_CAP) begin
        cmd.nbits <= 5'(cmd.nbits + {2'h0, in_w});
      end
    end
  end

  // Status byte for the opcode, and the byte that starts the next output slot.
  always_comb begin
    case (cmd.op)
      OP_RD_STAT2: stat_byte = core_s2.status[15:8];
      OP_RD_STAT3: stat_byte = core_s2.status[23:16];
      default: stat_byte = core_s2.status[7:0];
    endcase
    next_byte = ob;
    if (out_cnt == 3'h0) begin
      next_byte = is_status_read(cmd.op) ? stat_byte : array_data_in;
    end
  end

  // Output lines change on falling edges and float outside the data phase.
  always_ff @(negedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      io_drive_out <= '{out: 4'h0, oe_n: 4'hF};
      ob <= 8'h00;
    end else if (phase == PH_OUT) begin
      if (lanes == 3'h4) begin
        io_drive_out <= '{out: next_byte[7:4], oe_n: 4'h0};
        ob <= {next_byte[3:0], 4'h0};
      end else if (lanes == 3'h2) begin
        io_drive_out <= '{out: {2'h0, next_byte[7:6]}, oe_n: 4'hC};
        ob <= {next_byte[5:0], 2'h0};
      end else begin
        io_drive_out <= '{out: {2'h0, next_byte[7], 1'b0}, oe_n: 4'hD};
        ob <= {next_byte[6:0], 1'b0};
      end
    end else begin
      io_drive_out <= '{out: 4'h0, oe_n: 4'hF};
    end
  end

  // Chip select and write protect synchronisers on the core clock.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      wp_s1 <= wp_n_in;
      wp_s2 <= wp_s1;
    end
  end

  // The tag toggles once per decoded opcode, so a frame cut inside its opcode
  // leaves nothing behind for the core to act on.
  // Decode of a finished frame and the merged status write value.
  always_comb begin
    fresh = cs_s2 && !cs_d && (cmd.tag != seen_tag);
    hw_prot = status_out[SRP_HI_BIT] || (status_out[SRP_LO_BIT] && !wp_s2);
    is_wr = (cmd.op == OP_WR_STAT1) || (cmd.op == OP_WR_STAT2) || (cmd.op == OP_WR_STAT3);
    len_ok = (cmd.nbits == DIN_BITS_ONE) || (cmd.nbits == DIN_BITS_TWO);
    wr_go = fresh && is_wr && len_ok && status_out[WEL_BIT] &&
            !status_out[WIP_BIT] && !hw_prot;
    soft_rst = fresh && rst_arm && (cmd.op == OP_RST_DEVICE);
    tw_done = status_out[WIP_BIT] && (tw_cnt == 32'h00000000);
    byte1 = (cmd.nbits == DIN_BITS_TWO) ? cmd.din[15:8] : cmd.din[7:0];
    wr_val = {16'h0000, byte1};
    wr_sel = 24'h0000FF;
    if (cmd.op == OP_WR_STAT1 && cmd.nbits == DIN_BITS_TWO) begin
      wr_val = {8'h00, cmd.din[7:0], byte1};
      wr_sel = 24'h00FFFF;
    end else if (cmd.op == OP_WR_STAT2) begin
      wr_val = {8'h00, byte1, 8'h00};
      wr_sel = 24'h00FF00;
    end else if (cmd.op == OP_WR_STAT3) begin
      wr_val = {byte1, 16'h0000};
      wr_sel = 24'hFF0000;
    end
    merged = (status_out & ~(wr_sel & STATUS_WR_MASK)) | (wr_val & wr_sel & STATUS_WR_MASK);
  end

  // Next status: cycle end first, so a latch set in the same cycle still wins.
  always_comb begin
    next_status = status_out;
    if (tw_done) begin
      next_status = pending;
      next_status[WIP_BIT] = 1'b0;
      next_status[WEL_BIT] = 1'b0;
    end
    if (fresh && cmd.op == OP_WR_ENABLE) begin
      next_status[WEL_BIT] = 1'b1;
    end
    if ((fresh && cmd.op == OP_WR_DISABLE) || soft_rst) begin
      next_status[WEL_BIT] = 1'b0;
    end
    if (wr_go && vol_wen) begin
      next_status = merged;
      next_status[WEL_BIT] = 1'b0;
    end else if (wr_go) begin
      next_status[WIP_BIT] = 1'b1;
    end
  end

  // Status register.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_out <= STATUS_RESET;
    end else begin
      status_out <= next_status;
    end
  end

  // The volatile path writes at once and leaves the timer idle.
  // Pending value and timer of the self-timed write cycle.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pending <= STATUS_RESET;
      tw_cnt <= 32'h00000000;
    end else if (wr_go && !vol_wen) begin
      pending <= merged;
      tw_cnt <= 32'(TW_CYCLES - 1);
    end else if (status_out[WIP_BIT] && tw_cnt != 32'h00000000) begin
      tw_cnt <= 32'(tw_cnt - 32'h00000001);
    end
  end

  // Volatile-write enable, reset arming and read parameters.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vol_wen <= 1'b0;
      rst_arm <= 1'b0;
      dummy_sel <= DUMMY_SEL_RESET;
      seen_tag <= 1'b0;
    end else if (fresh) begin
      seen_tag <= cmd.tag;
      rst_arm <= cmd.op == OP_RST_ENABLE;
      if (soft_rst) begin
        vol_wen <= 1'b0;
        dummy_sel <= DUMMY_SEL_RESET;
      end else if (cmd.op == OP_VOL_ENABLE) begin
        vol_wen <= 1'b1;
      end else if (wr_go) begin
        vol_wen <= 1'b0;
      end
      if (cmd.op == OP_SET_PARAM && len_ok) begin
        dummy_sel <= byte1[5:4];
      end
    end
  end

endmodule

/* hw/sfl_pkg.sv */
// How it works
// - Status reads are accepted anytime, even during a running write cycle.
// - The selected status byte repeats on the output while chip select stays low.
// - Opcode 05H shifts out status bits 7 down to 0, MSB first.
// - Status-write opcodes are ignored unless the write enable latch is set.
// - Status writes never change bits 23, 20..15, 1 and 0.
// - A status write counts only when it ends after 8 or 16 data bits.
// - 01H with 16 bits writes registers one and two; with 8, only one.
// - A valid write starts a timed cycle; busy flag set, then busy and latch clear.
// - Status writes set protect bits, and are refused in hardware protected mode.
// - 50H leaves the latch alone and makes the next write volatile.
// - 03H takes a 24-bit address on rising edges, sends data on falling edges.
// - The read address advances after every output byte until chip select rises.
// - A 03H read during a running write cycle is rejected.
// - 03H is accepted only in single-line mode.
// - 0BH in single-line mode takes address plus one dummy byte before data.
// - In four-line mode the fast-read dummy count comes from the C0h parameter.
// - Dummy count returns to two at power-up and after software reset.
// - 3BH takes address and dummy byte serially, then sends two bits per clock.
// - Dual output puts odd bits on line one, even bits on line zero.
// - 6BH takes address and dummy byte serially, then sends four bits per clock.
// - Four-line output sends the upper nibble first, line n carries bit n+4.
// - Dual and quad output reads are refused in four-line mode.
// - Opcode, address and data are shifted most significant bit first.
package sfl_pkg;

  // Core clock period and the default length of a status write cycle.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TW_NS_DEFAULT = 1000000;

  // Command opcodes.
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
  localparam logic [7:0] OP_RD_STAT1 = 8'h05;
  localparam logic [7:0] OP_RD_STAT2 = 8'h35;
  localparam logic [7:0] OP_RD_STAT3 = 8'h15;
  localparam logic [7:0] OP_WR_STAT1 = 8'h01;
  localparam logic [7:0] OP_WR_STAT2 = 8'h31;
  localparam logic [7:0] OP_WR_STAT3 = 8'h11;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_READ = 8'h3B;
  localparam logic [7:0] OP_QUAD_READ = 8'h6B;
  localparam logic [7:0] OP_SET_PARAM = 8'hC0;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST_DEVICE = 8'h99;

  // Status bit positions.
  localparam int WIP_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int SRP_LO_BIT = 7;
  localparam int SRP_HI_BIT = 8;

  // Reset values and the mask of bits that a status write may change.
  localparam logic [23:0] STATUS_RESET = 24'h000000;
  localparam logic [23:0] STATUS_WR_MASK = 24'h607FFC;
  localparam logic [1:0] DUMMY_SEL_RESET = 2'h0;

  // Phase lengths in clocks, counted from zero, and data-in bit counts.
  localparam logic [5:0] OPC_LAST_SPI = 6'h07;
  localparam logic [5:0] OPC_LAST_QPI = 6'h01;
  localparam logic [5:0] ADDR_LAST_SPI = 6'h17;
  localparam logic [5:0] ADDR_LAST_QPI = 6'h05;
  localparam logic [5:0] DUMMY_LAST_SPI = 6'h07;
  localparam logic [4:0] DIN_BITS_ONE = 5'h08;
  localparam logic [4:0] DIN_BITS_TWO = 5'h10;
  localparam logic [4:0] DIN_BITS_CAP = 5'h18;

  // Command captured on the link side and read by the core at chip select rise.
  typedef struct packed {
    logic tag;
    logic [7:0] op;
    logic [15:0] din;
    logic [4:0] nbits;
  } sfl_cmd_t;

  // Core state copied to the link side.
  typedef struct packed {
    logic [23:0] status;
    logic [1:0] dummy_sel;
  } sfl_core_t;

  // Data line drive: level and active-low enable per line.
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
  } sfl_pins_t;

  // Last dummy clock index for a four-line fast read.
  function automatic logic [5:0] dummy_last(input logic [1:0] sel);
    logic [5:0] r;
    r = 6'h01;
    case (sel)
      2'h0: r = 6'h01;
      2'h1: r = 6'h03;
      2'h2: r = 6'h05;
      default: r = 6'h07;
    endcase
    return r;
  endfunction

  // Last clock index of one output byte for a given line count.
  function automatic logic [2:0] byte_last(input logic [2:0] lanes);
    logic [2:0] r;
    r = 3'h7;
    if (lanes == 3'h4) begin
      r = 3'h1;
    end else if (lanes == 3'h2) begin
      r = 3'h3;
    end
    return r;
  endfunction

  // True for the three status read opcodes.
  function automatic logic is_status_read(input logic [7:0] op);
    return (op == OP_RD_STAT1) || (op == OP_RD_STAT2) || (op == OP_RD_STAT3);
  endfunction

endpackage

/* verif/sfl_flash_cmd_props.sv */
`timescale 1ns/1ps
module sfl_flash_cmd_props
  import sfl_pkg::*;
#(
  parameter int TW_NS = TW_NS_DEFAULT
) (
  // Clocks and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  // Link and pins.
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  input sfl_pkg::sfl_pins_t io_drive_out,
  input wire logic wp_n_in,
  input wire logic four_line_mode_in,
  // Array and status.
  input wire logic [23:0] array_addr_out,
  input wire logic [7:0] array_data_in,
  input wire logic [23:0] status_out,
  input wire logic write_in_progress_flag_out
);
  localparam int TW_CYC = (TW_NS + 24) / 25;
  int busy_cnt;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Length of the current run of busy cycles.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= write_in_progress_flag_out ? busy_cnt + 1 : 0;
    end
  end
  AST_BUSY_BIT: assert property ($rose(write_in_progress_flag_out) |-> $past(cs_n_in))
    else $error("write cycle started with chip select low");
  AST_CS_RELEASE: assert property (cs_n_in |-> io_drive_out.oe_n == 4'hF)
    else $error("line driven while deselected");
  AST_FIXED_BITS: assert property ((status_out & 24'h9F8000) == 24'h0)
    else $error("fixed status bit changed");
  AST_CYCLE_LEN: assert property (
    $fell(write_in_progress_flag_out) |-> busy_cnt inside {[TW_CYC - 1:TW_CYC + 1]})
    else $error("write cycle length wrong");
  AST_LATCH_CLR: assert property ($fell(write_in_progress_flag_out) |-> !status_out[1])
    else $error("latch not cleared at cycle end");
  AST_NEED_LATCH: assert property ($rose(write_in_progress_flag_out) |-> status_out[1])
    else $error("cycle started without latch");
  AST_PROTECTED: assert property (
    status_out[7] && !wp_n_in && !$past(wp_n_in, 4) && !write_in_progress_flag_out
    |=> $stable(status_out[23:2]) && !write_in_progress_flag_out)
    else $error("status changed while protected");
  AST_LANES: assert property (
    !cs_n_in |-> io_drive_out.oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
    else $error("illegal line enable set");
endmodule
bind sfl_flash_cmd sfl_flash_cmd_props #(.TW_NS(TW_NS)) i_props (
  .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .io_in(io_in),
  .io_drive_out(io_drive_out), .wp_n_in(wp_n_in), .four_line_mode_in(four_line_mode_in),
  .array_addr_out(array_addr_out), .array_data_in(array_data_in), .status_out(status_out),
  .write_in_progress_flag_out(write_in_progress_flag_out));

/* verif/sfl_host_model.sv */
`timescale 1ns/1ps
module sfl_host_model
  import sfl_pkg::*;
(
  // Link toward the device.
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_out,
  // Device line drive.
  input sfl_pkg::sfl_pins_t drive_in
);
  logic [3:0] hval;
  logic hen;
  // A line carries the device, else the host, else its pull-up.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_out[i] = !drive_in.oe_n[i] ? drive_in.out[i] : (hen ? hval[i] : 1'b1);
    end
  end
  // The link clock rests low between frames; idle levels land once every process waits.
  initial begin
    sclk_out <= 1'b0;
    cs_n_out <= 1'b1;
    hval = 4'h0;
    hen = 1'b0;
  end
  // Sends ntx clocks tl bits wide from the top of tx, then reads nrx clocks rl bits wide.
  task automatic frame(input logic [63:0] tx, input int tl, input int ntx, input int rl,
                       input int nrx, output logic [63:0] rx);
    rx = 64'h0;
    cs_n_out = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      hen = i < ntx;
      hval = (tl == 4) ? tx[63:60] : {3'h0, tx[63]};
      tx = tx << tl;
      #80;
      sclk_out = 1'b1;
      if (i >= ntx) begin
        rx = (rl == 4) ? {rx[59:0], io_out} :
             (rl == 2) ? {rx[61:0], io_out[1:0]} : {rx[62:0], io_out[1]};
      end
      #80;
      sclk_out = 1'b0;
    end
    hen = 1'b0;
    #80;
    cs_n_out = 1'b1;
    #240;
  endtask
endmodule

/* verif/tb_sfl_flash_cmd.sv */
`timescale 1ns/1ps
module tb_sfl_flash_cmd;
  import sfl_pkg::*;
  logic clk_in, rst_in, sclk, cs_n, wp_n_in, four_line_mode_in, busy;
  logic [3:0] io;
  sfl_pins_t drv;
  logic [23:0] addr, status;
  logic [63:0] rx;
  int err_count, compares;
  // Array contents are a fixed pattern of the address.
  function automatic logic [7:0] mem(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  sfl_flash_cmd #(.TW_NS(20000)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .io_in(io), .io_drive_out(drv), .wp_n_in(wp_n_in),
    .four_line_mode_in(four_line_mode_in), .array_addr_out(addr),
    .array_data_in(mem(addr[7:0])), .status_out(status), .write_in_progress_flag_out(busy));
  sfl_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .io_out(io), .drive_in(drv));
  // Core clock.
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Compares one value and counts the result.
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // Sends a bare opcode over tl lines.
  task automatic op1(input logic [7:0] o, input int tl);
    i_host.frame({o, 56'h0}, tl, 8 / tl, 1, 0, rx);
  endtask
  // Waits, bounded, until the write cycle is over.
  task automatic wait_idle();
    repeat (8) @(posedge clk_in);
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk_in);
    #1;
  endtask
  // One status write with optional enables; the latch bit is left out of the compare.
  task automatic wstep(input logic [7:0] op, input logic [15:0] d, input int n,
                       input logic we, input logic vol, input logic wp, input logic [23:0] e);
    @(posedge clk_in);
    wp_n_in <= wp;
    if (we) op1(OP_WR_ENABLE, 1);
    if (vol) begin
      op1(OP_VOL_ENABLE, 1);
      chk("latch after volatile enable", 64'h1, status[1]);
    end
    i_host.frame({op, d, 40'h0}, 1, 8 + n, 1, 0, rx);
    if (we && n == 16) begin
      i_host.frame({OP_READ, 56'h0}, 1, 32, 1, 8, rx);
      chk("read during cycle", 64'hFF, rx);
      i_host.frame({OP_RD_STAT1, 56'h0}, 1, 8, 1, 8, rx);
      chk("busy bit read", 64'h1, rx & 64'h1);
    end
    wait_idle();
    chk("status", e, status & 24'hFFFFFD);
  endtask
  task automatic t_status_write();
    wstep(OP_WR_STAT1, 16'hFFFF, 16, 0, 0, 1, 24'h000000);
    wstep(OP_WR_STAT1, 16'hFFFF, 12, 1, 0, 1, 24'h000000);
    chk("latch kept after refused write", 64'h1, status[1]);
    op1(OP_WR_DISABLE, 1);
    chk("latch after write disable", 64'h0, status[1]);
    wstep(OP_WR_STAT1, 16'hFF42, 16, 1, 0, 1, 24'h0042FC);
    wstep(OP_WR_STAT1, 16'h0000, 8, 1, 0, 0, 24'h0042FC);
    wstep(OP_WR_STAT1, 16'h0000, 8, 1, 0, 1, 24'h004200);
    wstep(OP_WR_STAT2, 16'h0200, 8, 1, 1, 1, 24'h000200);
    wstep(OP_WR_STAT3, 16'hFF00, 8, 1, 0, 1, 24'h600200);
    wstep(OP_WR_STAT1, 16'h5C02, 16, 1, 0, 1, 24'h60025C);
    $display("status write test done");
  endtask
  task automatic t_status_read();
    logic [7:0] op [3];
    logic [23:0] e;
    logic [7:0] b;
    op = '{OP_RD_STAT1, OP_RD_STAT2, OP_RD_STAT3};
    e = 24'h60025C;
    for (int k = 0; k < 3; k++) begin
      b = e[8 * k +: 8];
      i_host.frame({op[k], 56'h0}, 1, 8, 1, 24, rx);
      chk("status byte", {40'h0, b, b, b}, rx);
    end
    $display("status read test done");
  endtask
  task automatic t_reads();
    logic [7:0] op [4];
    int ln [4];
    logic [63:0] e;
    op = '{OP_READ, OP_FAST_READ, OP_DUAL_READ, OP_QUAD_READ};
    ln = '{1, 1, 2, 4};
    e = {40'h0, mem(8'hFE), mem(8'hFF), mem(8'h00)};
    for (int k = 0; k < 4; k++) begin
      i_host.frame({op[k], 24'h0000FE, 32'h0}, 1, (k > 0) ? 40 : 32, ln[k], 24 / ln[k], rx);
      chk("stream", e, rx);
    end
    $display("array read test done");
  endtask
  task automatic t_four_line();
    logic [7:0] op [3];
    logic [63:0] e;
    op = '{OP_READ, OP_DUAL_READ, OP_QUAD_READ};
    e = {48'h0, mem(8'h10), mem(8'h11)};
    @(posedge clk_in);
    four_line_mode_in <= 1'b1;
    op1(8'h00, 4);
    for (int k = 0; k < 3; k++) begin
      i_host.frame({op[k], 24'h000010, 32'h0}, 4, 16, 4, 2, rx);
      chk("refused read", 64'hFF, rx);
    end
    i_host.frame({OP_RD_STAT1, 56'h0}, 4, 2, 4, 4, rx);
    chk("four-line status", 64'h5C5C, rx);
    for (int s = 0; s < 5; s++) begin
      if (s < 4) begin
        i_host.frame({OP_SET_PARAM, 2'h0, s[1:0], 52'h0}, 4, 4, 1, 0, rx);
      end else begin
        op1(OP_RST_ENABLE, 4);
        op1(OP_RST_DEVICE, 4);
      end
      i_host.frame({OP_FAST_READ, 24'h000010, 32'h0}, 4, (s < 4) ? 10 + 2 * s : 10, 4, 4, rx);
      chk("four-line fast read", e, rx);
    end
    @(posedge clk_in);
    four_line_mode_in <= 1'b0;
    op1(8'h00, 1);
    $display("four-line test done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reset, then the scenarios in order.
  initial begin
    rst_in <= 1'b1; // Lands after every process waits, so no reset edge is missed.
    wp_n_in <= 1'b1;
    four_line_mode_in <= 1'b0;
    err_count = 0;
    compares = 0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_status_write();
    t_status_read();
    t_reads();
    t_four_line();
    complete_run();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
endmodule
